// file: design/tape_io_pkg.sv
// Package: constants, register map and carriers for the tape reader I/O control
package tape_io_pkg;

  localparam int          CLK_MHZ        = 40;
  // Width of each reader sample pulse in microseconds
  localparam int          SAMPLE_US      = 100;
  localparam int          SAMPLE_CYC     = SAMPLE_US * CLK_MHZ;
  localparam int          CNT_W          = 12;

  localparam logic [31:0] OPER_OFFSET    = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET  = 32'h0000_0004;
  localparam logic [31:0] OPER_RESET     = 32'h0000_0000;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Operator panel, one bit per switch, held high while pressed
  typedef struct packed {
    logic reader_offline;
    logic parity_inhibit;
    logic single_char;
    logic reader_to_comp;
    logic parity_reset;
    logic master_reset;
    logic stop_read;
    logic start_read;
    logic start_compute;
  } oper_s;

  localparam int          OPER_W         = $bits(oper_s);

  // Read-only view of the block's own state
  typedef struct packed {
    logic       ready_sync;
    logic       parity_err;
    logic       offline_sample;
    logic       sample;
    logic       offline_advance;
    logic       advance;
    logic       input_mode;
    logic       reader_sel;
    logic [7:0] offline_char;
    logic [7:0] char_bits;
  } status_s;

endpackage

// file: design/tape_reader_io_sync_control.sv
// Tape reader character I/O control with AXI4-Lite operator registers
//
// Contract
// - Start-compute on button, stop code with inhibit or error, or single-char ready.
// - Ready-sync needs device ready, start-read released, no error or inhibit.
// - Reader select sets on select with bits 3-6 zero, or reader button.
// - Reader select clears on select with bit 6 zero and bit 3-5 one.
// - Reader select clears when off-line reader switch becomes active.
// - Input mode sets on input-command strobe or start-read button.
// - Input mode clears on start-compute, select, single-char begin, or stop-read.
// - Advance sets only with input mode and all-devices-ready query.
// - Advance clears at trailing edge of the reader sample pulse.
// - Master-reset button also drives the select strobe.
// - On-line sample triggers on cam 1, select, advance, reader on-line.
// - Sample pulse is a fixed-width one-shot started by its trigger.
// - Off-line sample ignores select; uses cam 1 and off-line advance.
// - Brush inputs set character bits during the sample pulse.
// - Seven-bit character register; a common clear zeros all bits.
// - Clear strobe on leading edge of output command or sample pulse.
// - Master or parity reset clears bit 6, sets bits 1-5 and 7.
// - While output strobe high, bits 1-6 load from output bits 7-2.
// - During output, with no clear, parity error sets bit 7.
// - Parity error on odd ones count, suppressed for the delete code.
// - All-devices-ready query is ready-sync AND input device ready.
// - Character-begin during sample with no clear, single-char or non-stop code.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps

// One-shot for the reader sample pulse. The counter sets the width, so a
// trigger that stays high for many cycles still gives a single pulse; a
// new pulse needs the trigger to fall and rise again after the count ends.
module tape_sample_one_shot
  import tape_io_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic trig,
  output logic      pulse
);
  logic [CNT_W-1:0] cnt_reg;
  logic             trig_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= trig;
    end
  end

  // Retrigger ignored while running, so the width never stretches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end else if (trig && !trig_reg) begin
      cnt_reg <= CNT_W'(SAMPLE_CYC);
    end
  end

  assign pulse = (cnt_reg != '0);
endmodule

module tape_reader_io_sync_control
  import tape_io_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        input_cmd,
  input  wire logic        output_cmd,
  input  wire logic [7:1]  out_bits,
  input  wire logic        select_cmd,
  input  wire logic        mem_ready,
  input  wire logic        out_dev_ready,
  input  wire logic        input_dev_ready,
  input  wire logic        offline_dev_ready,
  input  wire logic        typewriter_func,
  input  wire logic        reader_cam1,
  input  wire logic [7:1]  brush,
  output logic             start_compute,
  output logic             ready_sync,
  output logic [7:1]       char_out,
  output logic [7:1]       offline_char_out,
  output logic             sample_out
);
  oper_s          oper_reg;
  logic [7:1]     char_reg;
  logic [7:1]     offline_char_reg;
  logic           reader_sel_reg;
  logic           input_mode_reg;
  logic           advance_reg;
  logic           offline_advance_reg;
  logic           start_compute_reg;
  logic           ready_sync_reg;
  logic           output_cmd_prev_reg;
  logic           sample_prev_reg;
  logic           offline_sample_prev_reg;
  logic           offline_prev_reg;
  logic           bvalid_reg;
  logic [1:0]     bresp_reg;
  logic           rvalid_reg;
  logic [1:0]     rresp_reg;
  logic [31:0]    rdata_reg;

  logic           sample;
  logic           offline_sample;
  logic           char_clear;
  logic           offline_clear;
  logic           select_strobe;
  logic           parity_err;
  logic           stop_code;
  logic           sc_term;
  logic           rs_term;
  logic           all_ready;
  logic           char_begin;
  logic           online_trig;
  logic           offline_trig;
  logic           wr_fire;
  logic           rd_fire;
  status_s        status;

  // Edge detectors compare against last cycle's sample of each source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_cmd_prev_reg     <= 1'b0;
      sample_prev_reg         <= 1'b0;
      offline_sample_prev_reg <= 1'b0;
      offline_prev_reg        <= 1'b0;
    end else begin
      output_cmd_prev_reg     <= output_cmd;
      sample_prev_reg         <= sample;
      offline_sample_prev_reg <= offline_sample;
      offline_prev_reg        <= oper_reg.reader_offline;
    end
  end

  assign char_clear    = (output_cmd && !output_cmd_prev_reg)
                       || (sample && !sample_prev_reg);
  assign offline_clear = offline_sample && !offline_sample_prev_reg;

  assign select_strobe = select_cmd || oper_reg.master_reset;

  // Delete code (all seven ones) would otherwise read as odd
  assign parity_err = (^char_reg) && !(&char_reg);
  assign stop_code  = (char_reg[6:1] == 6'h00);

  // The stop-code path waits until the clear cycle of the sample has
  // passed, so it only judges the freshly read character
  assign sc_term = oper_reg.start_compute
                 || (oper_reg.single_char && mem_ready)
                 || ((oper_reg.parity_inhibit || parity_err)
                     && !oper_reg.single_char && stop_code
                     && !char_clear && sample);

  // Holding start-read drops ready-sync, which also keeps advance off
  assign rs_term = out_dev_ready && !oper_reg.start_read
                 && (!parity_err || oper_reg.parity_inhibit);

  assign all_ready = rs_term && input_dev_ready;

  assign char_begin = sample && !char_clear
                    && (oper_reg.single_char
                        || (!stop_code && !typewriter_func));

  assign online_trig  = reader_cam1 && reader_sel_reg && advance_reg
                      && !oper_reg.reader_offline;
  assign offline_trig = reader_cam1 && offline_advance_reg
                      && oper_reg.reader_offline;

  tape_sample_one_shot u_online_shot (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trig    (online_trig),
    .pulse   (sample)
  );

  tape_sample_one_shot u_offline_shot (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trig    (offline_trig),
    .pulse   (offline_sample)
  );

  // Strobes to the computer are registered for clean timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_compute_reg <= 1'b0;
      ready_sync_reg    <= 1'b0;
    end else begin
      start_compute_reg <= sc_term;
      ready_sync_reg    <= rs_term;
    end
  end

  // Operator set terms win over the select strobe
  // The off-line leading-edge clear comes last, so a select code seen in
  // the same cycle decides the flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reader_sel_reg <= 1'b0;
    end else if ((select_strobe && char_reg[6:3] == 4'h0)
                 || oper_reg.reader_to_comp) begin
      reader_sel_reg <= 1'b1;
    end else if (select_strobe && !char_reg[6]
                 && (char_reg[5:3] != 3'h0)) begin
      reader_sel_reg <= 1'b0;
    end else if (oper_reg.reader_offline && !offline_prev_reg) begin
      reader_sel_reg <= 1'b0;
    end
  end

  // Input mode serves both on-line and off-line reading
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_mode_reg <= 1'b0;
    end else if (input_cmd || oper_reg.start_read) begin
      input_mode_reg <= 1'b1;
    end else if (sc_term || select_strobe || oper_reg.stop_read
                 || (char_begin && oper_reg.single_char)) begin
      input_mode_reg <= 1'b0;
    end
  end

  // Trailing-edge clear wins, so a set term that still holds restarts the
  // read one cycle later, never inside the pulse that just ended
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      advance_reg <= 1'b0;
    end else if (!sample && sample_prev_reg) begin
      advance_reg <= 1'b0;
    end else if (input_mode_reg && all_ready) begin
      advance_reg <= 1'b1;
    end
  end

  // Start-read held down keeps the off-line read from starting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offline_advance_reg <= 1'b0;
    end else if (!offline_sample && offline_sample_prev_reg) begin
      offline_advance_reg <= 1'b0;
    end else if (input_mode_reg && oper_reg.reader_offline
                 && offline_dev_ready && !oper_reg.start_read) begin
      offline_advance_reg <= 1'b1;
    end
  end

  // Order: common clear, then brush and output sets, then panel reset
  // Output bits are ORed in on every cycle of the strobe, so the computer
  // must keep them steady from the strobe's leading edge until it falls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      char_reg <= 7'h00;
    end else if (oper_reg.master_reset || oper_reg.parity_reset) begin
      char_reg <= {1'b1, 1'b0, 5'h1f};
    end else begin
      char_reg <= (char_clear ? 7'h00 : char_reg)
                | (sample ? brush : 7'h00)
                | (output_cmd ? {1'b0, out_bits[2], out_bits[3],
                                 out_bits[4], out_bits[5], out_bits[6],
                                 out_bits[7]} : 7'h00)
                | {output_cmd && !char_clear && parity_err,
                   6'h00};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offline_char_reg <= 7'h00;
    end else begin
      offline_char_reg <= (offline_clear ? 7'h00 : offline_char_reg)
                        | (offline_sample ? brush : 7'h00);
    end
  end

  assign status.ready_sync      = ready_sync_reg;
  assign status.parity_err      = parity_err;
  assign status.offline_sample  = offline_sample;
  assign status.sample          = sample;
  assign status.offline_advance = offline_advance_reg;
  assign status.advance         = advance_reg;
  assign status.input_mode      = input_mode_reg;
  assign status.reader_sel      = reader_sel_reg;
  assign status.offline_char    = {1'b0, offline_char_reg};
  assign status.char_bits       = {1'b0, char_reg};

  // AXI4-Lite: address and data taken together, one of each in flight
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_wready  = s_axi_awready;
  assign wr_fire       = s_axi_awready;
  assign s_axi_arready = !rvalid_reg;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  // Byte lanes above bit 8 hold nothing, so lanes 2 and 3 are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oper_reg <= oper_s'(OPER_RESET[OPER_W-1:0]);
    end else if (wr_fire && s_axi_awaddr[31:2] == OPER_OFFSET[31:2]) begin
      oper_reg <= oper_s'({s_axi_wstrb[1] ? s_axi_wdata[OPER_W-1:8]
                                          : oper_reg[OPER_W-1:8],
                           s_axi_wstrb[0] ? s_axi_wdata[7:0]
                                          : oper_reg[7:0]});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (s_axi_awaddr[31:2] == OPER_OFFSET[31:2])
                  ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      if (s_axi_araddr[31:2] == OPER_OFFSET[31:2]) begin
        rresp_reg <= RESP_OKAY;
        rdata_reg <= {{(32-OPER_W){1'b0}}, oper_reg};
      end else if (s_axi_araddr[31:2] == STATUS_OFFSET[31:2]) begin
        rresp_reg <= RESP_OKAY;
        rdata_reg <= {{(32-$bits(status_s)){1'b0}}, status};
      end else begin
        rresp_reg <= RESP_SLVERR;
        rdata_reg <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid     = bvalid_reg;
  assign s_axi_bresp      = bresp_reg;
  assign s_axi_rvalid     = rvalid_reg;
  assign s_axi_rresp      = rresp_reg;
  assign s_axi_rdata      = rdata_reg;
  assign start_compute    = start_compute_reg;
  assign ready_sync       = ready_sync_reg;
  assign char_out         = char_reg;
  assign offline_char_out = offline_char_reg;
  assign sample_out       = sample;
endmodule

// file: verif/tape_io_props.sv
// Port checker for the tape reader I/O control
`timescale 1ns/10ps
module tape_io_props
  import tape_io_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       output_cmd,
  input wire logic [7:1] out_bits,
  input wire logic       out_dev_ready,
  input wire logic       reader_cam1,
  input wire logic [7:1] brush,
  input wire logic       s_axi_bvalid,
  input wire logic       ready_sync,
  input wire logic [7:1] char_out,
  input wire logic       sample_out
);
  logic [12:0] hi_cnt;
  logic [6:1]  mapped;

  assign mapped = {out_bits[2], out_bits[3], out_bits[4], out_bits[5],
                   out_bits[6], out_bits[7]};

  // Cycles the sample pulse has been high so far
  always_ff @(posedge aclk) begin
    if (!aresetn || !sample_out) begin
      hi_cnt <= 13'h0000;
    end else begin
      hi_cnt <= hi_cnt + 13'h0001;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pulse_width: assert property (
    $fell(sample_out) |-> hi_cnt == SAMPLE_CYC)
    else $error("sample pulse width wrong");
  a_sample_cause: assert property (
    $rose(sample_out) |-> $past(reader_cam1))
    else $error("sample started without cam");
  a_sample_load: assert property (
    $rose(sample_out) && !output_cmd |=> char_out == $past(brush))
    else $error("character not cleared and loaded");
  a_brush_hold: assert property (
    sample_out && $past(sample_out) && !output_cmd
    |=> (char_out & $past(brush)) == $past(brush))
    else $error("brush bit lost during sample");
  a_out_load: assert property (
    output_cmd && !$past(output_cmd) && $past(aresetn) && !sample_out
    |=> char_out[6:1] == $past(mapped) && !char_out[7])
    else $error("output bits not loaded");
  a_parity_fill: assert property (
    output_cmd && $past(output_cmd) && $past(aresetn) && !sample_out
    && ^char_out && char_out != 7'h7f |=> char_out[7])
    else $error("parity bit not added");
  a_char_hold: assert property (
    $changed(char_out) |-> $past(output_cmd) || $past(sample_out)
    || $past(s_axi_bvalid))
    else $error("character changed with no cause");
  a_ready_dev: assert property (
    ready_sync |-> $past(out_dev_ready))
    else $error("ready without output device");

  cover property ($rose(sample_out));
  cover property ($rose(output_cmd));
  cover property ($rose(ready_sync));
endmodule

bind tape_reader_io_sync_control tape_io_props i_props (
  .aclk, .aresetn, .output_cmd, .out_bits, .out_dev_ready, .reader_cam1,
  .brush, .s_axi_bvalid, .ready_sync, .char_out, .sample_out
);

// file: verif/tape_reader_model.sv
// Behavioural paper tape reader: cam timing and brush levels
`timescale 1ns/10ps
module tape_reader_model (
  input  wire logic       aclk,
  input  wire logic       run,
  input  wire logic [7:1] holes,
  output logic            reader_cam1,
  output logic [7:1]      brush
);
  logic [5:0] phase_reg;

  always_ff @(posedge aclk) begin
    if (!run) begin
      phase_reg <= 6'h00;
    end else begin
      phase_reg <= phase_reg + 6'h01;
    end
  end

  // Cam closes once a turn; a stopped reader leaves it open
  assign reader_cam1 = run && (phase_reg < 6'h08);
  // Brushes off tape float, so show the opposite pattern
  assign brush = run ? holes : ~holes;
endmodule

// file: verif/testbench.sv
// Self-checking bench for the tape reader I/O control
`timescale 1ns/10ps
module testbench
  import tape_io_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        input_cmd, output_cmd, select_cmd, out_dev_ready, run;
  logic        input_dev_ready, typewriter_func, reader_cam1, sc_seen;
  logic        start_compute, ready_sync, sample_out;
  logic        mem_ready, offline_dev_ready;
  logic [7:1]  out_bits, brush, holes, char_out, offline_char_out;
  logic [7:1]  obs [2] = '{7'h06, 7'h04};
  int          miscompares, cmp_count, cyc;

  tape_reader_io_sync_control i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .input_cmd,
    .output_cmd, .out_bits, .select_cmd, .mem_ready, .out_dev_ready,
    .input_dev_ready, .offline_dev_ready, .typewriter_func,
    .reader_cam1, .brush, .start_compute, .ready_sync, .char_out,
    .offline_char_out, .sample_out
  );
  tape_reader_model i_reader (.aclk, .run, .holes, .reader_cam1, .brush);

  task automatic chk(input string n, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready  <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready  <= 1'b0;
  endtask

  task automatic st(input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(STATUS_OFFSET, d, r);
    chk("status", e, d);
  endtask

  task automatic sel_pulse;
    @(posedge aclk);
    select_cmd <= 1'b1;
    @(posedge aclk);
    select_cmd <= 1'b0;
  endtask

  // Output bits land reversed; bit 7 evens out the ones
  function automatic logic [7:1] exp_out(input logic [7:1] ob);
    logic [7:1] r;
    for (int i = 1; i <= 6; i++) r[i] = ob[8 - i];
    r[7] = ^r[6:1];
    return r;
  endfunction

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (start_compute === 1'b1) sc_seen <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      conclude;
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, input_cmd, output_cmd, select_cmd, out_dev_ready} = '0;
    {input_dev_ready, typewriter_func, run, sc_seen} = '0;
    {mem_ready, offline_dev_ready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, out_bits, holes} = '0;
    {miscompares, cmp_count, cyc} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OPER_OFFSET, rdat, resp);
    chk("oper", OPER_RESET, rdat);
    rd(32'h0000_0008, rdat, resp);
    chk("unmapped", 32'(RESP_SLVERR), 32'(resp));
    wr(STATUS_OFFSET, 32'hffff_ffff, resp);
    chk("ro write", 32'(RESP_SLVERR), 32'(resp));
    st(32'h0000_0000);
    sel_pulse;
    st(32'h0001_0000);
    wr(OPER_OFFSET, 32'h0000_0100, resp);
    st(32'h0000_0000);
    wr(OPER_OFFSET, 32'h0000_0000, resp);
    sel_pulse;
    out_dev_ready   <= 1'b1;
    input_dev_ready <= 1'b1;
    holes           <= 7'h40;
    run             <= 1'b1;
    st(32'h0081_0000);
    input_cmd <= 1'b1;
    @(posedge aclk);
    input_cmd <= 1'b0;
    while (sample_out !== 1'b1) @(posedge aclk);
    while (sample_out === 1'b1) @(posedge aclk);
    repeat (4) @(posedge aclk);
    chk("char", 32'h0000_0040, 32'(char_out));
    chk("start compute", 32'h0000_0001, 32'(sc_seen));
    st(32'h0041_0040);
    run             <= 1'b0;
    typewriter_func <= 1'b1;
    foreach (obs[i]) begin
      out_bits   <= obs[i];
      output_cmd <= 1'b1;
      repeat (3) @(posedge aclk);
      output_cmd <= 1'b0;
      @(posedge aclk);
      chk("out char", 32'(exp_out(obs[i])), 32'(char_out));
    end
    wr(OPER_OFFSET, 32'h0000_0008, resp);
    wr(OPER_OFFSET, 32'h0000_0000, resp);
    st(32'h0080_005f);
    wr(OPER_OFFSET, 32'h0000_0001, resp);
    repeat (2) @(posedge aclk);
    chk("button", 32'h0000_0001, 32'(start_compute));
    wr(OPER_OFFSET, 32'h0000_0000, resp);
    input_dev_ready <= 1'b0;
    wr(OPER_OFFSET, 32'h0000_0002, resp);
    st(32'h0002_005f);
    wr(OPER_OFFSET, 32'h0000_0004, resp);
    st(32'h0080_005f);
    mem_ready <= 1'b1;
    wr(OPER_OFFSET, 32'h0000_0040, resp);
    repeat (2) @(posedge aclk);
    chk("single char", 32'h0000_0001, 32'(start_compute));
    mem_ready <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("single idle", 32'h0000_0000, 32'(start_compute));
    wr(OPER_OFFSET, 32'h0000_0020, resp);
    wr(OPER_OFFSET, 32'h0000_0000, resp);
    st(32'h0081_005f);
    offline_dev_ready <= 1'b1;
    holes             <= 7'h03;
    wr(OPER_OFFSET, 32'h0000_0100, resp);
    run       <= 1'b1;
    input_cmd <= 1'b1;
    @(posedge aclk);
    input_cmd <= 1'b0;
    repeat (100) @(posedge aclk);
    wr(OPER_OFFSET, 32'h0000_0104, resp);
    repeat (SAMPLE_CYC) @(posedge aclk);
    chk("offline char", 32'h0000_0003, 32'(offline_char_out));
    st(32'h0080_035f);
    conclude;
  end
endmodule
